// ==== rtl/atb_bridge.sv ====
`timescale 1ns/1ps
module atb_bridge (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic ce_in,
    input wire logic [7:0] addr_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [15:0] wdata_in,
    input wire logic bus16_in,
    input wire logic master_in,
    input wire logic [1:0] dma_mode_in,
    input wire logic dma_start_in,
    input wire logic dma_read_in,
    input wire logic [15:0] dd_in,
    output logic [15:0] rdata_out,
    output logic ack_out,
    output logic busy_out,
    output logic dma_done_out,
    output logic cs1_out,
    output logic cs0_out,
    output logic [2:0] da_out,
    output logic dior_n_out,
    output logic diow_n_out,
    output logic [15:0] dd_out,
    output logic dd_oe_out
);

    // ==========================================================
    // drive data pin synchroniser
    logic [15:0] dd_s1_ff, dd_s2_ff, dd_s3_ff, dd_stable_ff, nxt_dd_stable;
    always_comb begin
        nxt_dd_stable = dd_stable_ff;
        if (dd_s2_ff == dd_s3_ff) begin
            nxt_dd_stable = dd_s3_ff;
        end
    end
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dd_s1_ff <= 16'h0000;
            dd_s2_ff <= 16'h0000;
            dd_s3_ff <= 16'h0000;
            dd_stable_ff <= 16'h0000;
        end else if (ce_in) begin
            dd_s1_ff <= dd_in;
            dd_s2_ff <= dd_s1_ff;
            dd_s3_ff <= dd_s2_ff;
            dd_stable_ff <= nxt_dd_stable;
        end
    end

    // ==========================================================
    // address decode
    logic hit;
    logic dec_cs1, dec_cs0;
    logic [2:0] dec_da;
    always_comb begin
        hit = 1'b1;
        dec_cs1 = 1'b1;
        dec_cs0 = 1'b0;
        dec_da = 3'h0;
        unique case (addr_in)
            atb_pkg::OFS_DATA: dec_da = 3'h0;
            atb_pkg::OFS_ERR_FEAT: dec_da = 3'h1;
            atb_pkg::OFS_SECT_CNT: dec_da = 3'h2;
            atb_pkg::OFS_SECT_NUM: dec_da = 3'h3;
            atb_pkg::OFS_CYL_LOW: dec_da = 3'h4;
            atb_pkg::OFS_CYL_HIGH: dec_da = 3'h5;
            atb_pkg::OFS_DRV_HEAD: dec_da = 3'h6;
            atb_pkg::OFS_CMD: dec_da = 3'h7;
            atb_pkg::OFS_ALT_STAT, atb_pkg::OFS_DRV_ADDR: begin
                dec_cs1 = 1'b0;
                dec_cs0 = 1'b1;
                dec_da = (addr_in == atb_pkg::OFS_DRV_ADDR)
                    ? atb_pkg::DA_DRV_ADDR : atb_pkg::DA_ALT_STAT;
            end
            default: hit = 1'b0;
        endcase
    end

    // ==========================================================
    // sequencer
    atb_pkg::atb_state_e state_ff, nxt_state;
    logic [4:0] cnt_ff, nxt_cnt, strobe_len_ff, nxt_strobe_len;
    logic [7:0] lo_byte_ff, nxt_lo_byte;
    logic half_ff, nxt_half, is_write_ff, nxt_is_write;
    logic is_data_ff, nxt_is_data, ack_ff, nxt_ack, busy_ff, nxt_busy;
    logic dma_done_ff, nxt_dma_done, dd_oe_ff, nxt_dd_oe;
    logic [15:0] rdata_ff, nxt_rdata, dd_ff, nxt_dd, launch_word;
    logic cs1_ff, nxt_cs1, cs0_ff, nxt_cs0, launch, data_8bit;
    logic [2:0] da_ff, nxt_da;
    logic dior_n_ff, nxt_dior_n, diow_n_ff, nxt_diow_n;
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_strobe_len = strobe_len_ff;
        nxt_lo_byte = lo_byte_ff;
        nxt_half = half_ff;
        nxt_is_write = is_write_ff;
        nxt_is_data = is_data_ff;
        nxt_rdata = rdata_ff;
        nxt_ack = 1'b0;
        nxt_dma_done = 1'b0;
        nxt_cs1 = cs1_ff;
        nxt_cs0 = cs0_ff;
        nxt_da = da_ff;
        nxt_dior_n = dior_n_ff;
        nxt_diow_n = diow_n_ff;
        nxt_dd = dd_ff;
        nxt_dd_oe = dd_oe_ff;
        launch = 1'b0;
        launch_word = wdata_in;
        data_8bit = (addr_in == atb_pkg::OFS_DATA) && !bus16_in;
        unique case (state_ff)
            atb_pkg::ST_IDLE: begin
                if (addr_in == atb_pkg::OFS_STROBE && (wr_in || rd_in)) begin
                    if (wr_in) begin
                        nxt_strobe_len = wdata_in[4:0];
                    end
                    // reserved bits read as zero
                    nxt_rdata = {11'h000, strobe_len_ff};
                    nxt_ack = 1'b1;
                end else if (hit && rd_in && addr_in == atb_pkg::OFS_CMD) begin
                    // command register is write only
                    nxt_rdata = atb_pkg::CMD_READ_VALUE;
                    nxt_ack = 1'b1;
                end else if (hit && wr_in && data_8bit) begin
                    // low byte first, pio on the high byte
                    if (!half_ff) begin
                        nxt_lo_byte = wdata_in[7:0];
                        nxt_half = 1'b1;
                        nxt_ack = 1'b1;
                    end else begin
                        launch = 1'b1;
                        launch_word = {wdata_in[7:0], lo_byte_ff};
                        nxt_half = 1'b0;
                    end
                end else if (hit && rd_in && data_8bit && half_ff) begin
                    // second read hands out the held high byte
                    nxt_rdata = {8'h00, lo_byte_ff};
                    nxt_half = 1'b0;
                    nxt_ack = 1'b1;
                end else if (hit && (wr_in || rd_in)) begin
                    launch = 1'b1;
                end else if (wr_in || rd_in) begin
                    nxt_rdata = 16'h0000;
                    nxt_ack = 1'b1;
                end else if (dma_start_in && master_in
                        && dma_mode_in == atb_pkg::DMA_MODE_MASTER) begin
                    // own strobes only in master mode 03H
                    nxt_state = atb_pkg::ST_DMA;
                    nxt_cnt = strobe_len_ff;
                    nxt_dior_n = !dma_read_in;
                    nxt_diow_n = dma_read_in;
                end
                if (launch) begin
                    // latch selects for the drive cycle
                    nxt_state = atb_pkg::ST_SETUP;
                    nxt_cnt = atb_pkg::PIO_SETUP_CYC - 5'h01;
                    nxt_cs1 = dec_cs1;
                    nxt_cs0 = dec_cs0;
                    nxt_da = dec_da;
                    nxt_is_write = wr_in;
                    nxt_is_data = addr_in == atb_pkg::OFS_DATA;
                    nxt_dd = nxt_is_data ? launch_word
                        : {8'h00, wdata_in[7:0]};
                    nxt_dd_oe = wr_in;
                end
            end
            atb_pkg::ST_SETUP: begin
                nxt_cnt = cnt_ff - 5'h01;
                if (cnt_ff == 5'h00) begin
                    nxt_state = atb_pkg::ST_ACTIVE;
                    nxt_cnt = atb_pkg::PIO_ACTIVE_CYC - 5'h01;
                    nxt_dior_n = is_write_ff;
                    nxt_diow_n = !is_write_ff;
                end
            end
            atb_pkg::ST_ACTIVE: begin
                nxt_cnt = cnt_ff - 5'h01;
                if (cnt_ff == 5'h00) begin
                    nxt_state = atb_pkg::ST_RECOVER;
                    nxt_cnt = atb_pkg::PIO_RECOVER_CYC - 5'h01;
                    nxt_dior_n = 1'b1;
                    nxt_diow_n = 1'b1;
                end
            end
            atb_pkg::ST_RECOVER: begin
                nxt_cnt = cnt_ff - 5'h01;
                nxt_dd_oe = 1'b0;
                if (cnt_ff == 5'h00) begin
                    nxt_state = atb_pkg::ST_IDLE;
                    nxt_cs1 = 1'b1;
                    nxt_cs0 = 1'b1;
                    nxt_da = 3'h0;
                    // strobe data clears the 3-flop sync only now
                    nxt_ack = 1'b1;
                    nxt_rdata = is_data_ff ? dd_stable_ff
                        : {8'h00, dd_stable_ff[7:0]};
                    // 8-bit read hands low byte, keeps high
                    if (is_data_ff && !bus16_in && !is_write_ff) begin
                        nxt_rdata = {8'h00, dd_stable_ff[7:0]};
                        nxt_lo_byte = dd_stable_ff[15:8];
                        nxt_half = 1'b1;
                    end
                end
            end
            atb_pkg::ST_DMA: begin
                // strobe lasts count plus one clocks
                nxt_cnt = cnt_ff - 5'h01;
                if (cnt_ff == 5'h00) begin
                    nxt_state = atb_pkg::ST_IDLE;
                    nxt_dior_n = 1'b1;
                    nxt_diow_n = 1'b1;
                    nxt_dma_done = 1'b1;
                end
            end
            default: begin
                nxt_state = atb_pkg::ST_IDLE;
                nxt_dior_n = 1'b1;
                nxt_diow_n = 1'b1;
            end
        endcase
        nxt_busy = nxt_state != atb_pkg::ST_IDLE;
    end
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_ff <= atb_pkg::ST_IDLE;
            cnt_ff <= 5'h00;
            strobe_len_ff <= atb_pkg::STROBE_CNT_RST;
            lo_byte_ff <= 8'h00;
            half_ff <= 1'b0;
            is_write_ff <= 1'b0;
            is_data_ff <= 1'b0;
            rdata_ff <= 16'h0000;
            ack_ff <= 1'b0;
            busy_ff <= 1'b0;
            dma_done_ff <= 1'b0;
            cs1_ff <= 1'b1;
            cs0_ff <= 1'b1;
            da_ff <= 3'h0;
            dior_n_ff <= 1'b1;
            diow_n_ff <= 1'b1;
            dd_ff <= 16'h0000;
            dd_oe_ff <= 1'b0;
        end else if (ce_in) begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            strobe_len_ff <= nxt_strobe_len;
            lo_byte_ff <= nxt_lo_byte;
            half_ff <= nxt_half;
            is_write_ff <= nxt_is_write;
            is_data_ff <= nxt_is_data;
            rdata_ff <= nxt_rdata;
            ack_ff <= nxt_ack;
            busy_ff <= nxt_busy;
            dma_done_ff <= nxt_dma_done;
            cs1_ff <= nxt_cs1;
            cs0_ff <= nxt_cs0;
            da_ff <= nxt_da;
            dior_n_ff <= nxt_dior_n;
            diow_n_ff <= nxt_diow_n;
            dd_ff <= nxt_dd;
            dd_oe_ff <= nxt_dd_oe;
        end
    end

    assign rdata_out = rdata_ff;
    assign ack_out = ack_ff;
    assign busy_out = busy_ff;
    assign dma_done_out = dma_done_ff;
    assign cs1_out = cs1_ff;
    assign cs0_out = cs0_ff;
    assign da_out = da_ff;
    assign dior_n_out = dior_n_ff;
    assign diow_n_out = diow_n_ff;
    assign dd_out = dd_ff;
    assign dd_oe_out = dd_oe_ff;

endmodule : atb_bridge

// ==== rtl/atb_pkg.sv ====
package atb_pkg;

    // ==========================================================
    // host register offsets
    localparam logic [7:0] OFS_DATA = 8'h40;
    localparam logic [7:0] OFS_CMD = 8'h44;
    localparam logic [7:0] OFS_ERR_FEAT = 8'h48;
    localparam logic [7:0] OFS_SECT_CNT = 8'h49;
    localparam logic [7:0] OFS_SECT_NUM = 8'h4a;
    localparam logic [7:0] OFS_CYL_LOW = 8'h4b;
    localparam logic [7:0] OFS_CYL_HIGH = 8'h4c;
    localparam logic [7:0] OFS_DRV_HEAD = 8'h4d;
    localparam logic [7:0] OFS_ALT_STAT = 8'h4e;
    localparam logic [7:0] OFS_DRV_ADDR = 8'h4f;
    localparam logic [7:0] OFS_STROBE = 8'h60;

    // ==========================================================
    // field layouts and reset values
    localparam int STROBE_CNT_W = 5;
    localparam logic [4:0] STROBE_CNT_RST = 5'h1f;
    localparam logic [1:0] DMA_MODE_MASTER = 2'h3;
    localparam logic [15:0] CMD_READ_VALUE = 16'h00ff;
    localparam logic [2:0] DA_ALT_STAT = 3'h6;
    localparam logic [2:0] DA_DRV_ADDR = 3'h7;

    // ==========================================================
    // pio timing, clk_in at 10 MHz
    localparam int CLK_PERIOD_NS = 100;
    localparam int PIO_SETUP_NS = 70;
    localparam int PIO_ACTIVE_NS = 290;
    localparam int PIO_RECOVER_NS = 200;
    // least times round up, never below one cycle
    localparam int PIO_SETUP_CYC_I =
        (PIO_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PIO_ACTIVE_CYC_I =
        (PIO_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PIO_RECOVER_CYC_I =
        (PIO_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] PIO_SETUP_CYC =
        5'((PIO_SETUP_CYC_I < 1) ? 1 : PIO_SETUP_CYC_I);
    localparam logic [4:0] PIO_ACTIVE_CYC =
        5'((PIO_ACTIVE_CYC_I < 1) ? 1 : PIO_ACTIVE_CYC_I);
    localparam logic [4:0] PIO_RECOVER_CYC =
        5'((PIO_RECOVER_CYC_I < 1) ? 1 : PIO_RECOVER_CYC_I);

    // ==========================================================
    // sequencer states
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_SETUP = 5'b00010,
        ST_ACTIVE = 5'b00100,
        ST_RECOVER = 5'b01000,
        ST_DMA = 5'b10000
    } atb_state_e;

endpackage : atb_pkg

// ==== testbench/atb_assertions.sv ====
`timescale 1ns/1ps
// ==========
// port checker for the task file bridge
module atb_assertions (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic wr_in,
    input wire logic [7:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic master_in,
    input wire logic [1:0] dma_mode_in,
    input wire logic dma_start_in,
    input wire logic busy_out,
    input wire logic ack_out,
    input wire logic dma_done_out,
    input wire logic cs1_out,
    input wire logic cs0_out,
    input wire logic [2:0] da_out,
    input wire logic dior_n_out,
    input wire logic diow_n_out,
    input wire logic dd_oe_out
);
    logic [4:0] len_ff;
    logic [5:0] cnt_ff;
    logic pio_lo, dma_lo;
    logic [2:0] da_exp;
    assign pio_lo = (cs1_out ^ cs0_out) & ~(dior_n_out & diow_n_out);
    assign dma_lo = cs1_out & cs0_out & ~(dior_n_out & diow_n_out);
    assign da_exp = (addr_in == 8'h44) ? 3'h7 :
        (addr_in[3] ? addr_in[2:0] + 3'h1 : 3'h0);
    // mirror of the strobe length; clock enable is held high by the bench
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            len_ff <= 5'h1f;
            cnt_ff <= 6'h00;
        end else begin
            cnt_ff <= dma_lo ? cnt_ff + 6'h01 : 6'h00;
            if (wr_in && !busy_out && addr_in == 8'h60)
                len_ff <= wdata_in[4:0];
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    AST_IDLE_CS: assert property (!busy_out |-> cs1_out && cs0_out)
        else $error("selects not idle");
    AST_PIO_WIDTH: assert property ($rose(pio_lo) |->
        pio_lo [*3] ##1 (!pio_lo && !ack_out) ##2 ack_out)
        else $error("pio strobe");
    AST_DMA_WIDTH: assert property ($fell(dma_lo) |->
        dma_done_out && cnt_ff == {1'b0, len_ff} + 6'h01)
        else $error("dma strobe length");
    AST_DMA_GATE: assert property ($rose(dma_lo) |->
        $past(master_in && dma_mode_in == 2'h3 && dma_start_in))
        else $error("dma strobe not allowed");
    AST_DA_MAP: assert property ($fell(cs0_out) |->
        cs1_out && da_out == $past(da_exp)) else $error("primary map");
    AST_ALT_MAP: assert property ($fell(cs1_out) |->
        cs0_out && da_out == {2'b11, $past(addr_in[0])})
        else $error("alternate map");
    AST_WR_OE: assert property (!diow_n_out && cs1_out != cs0_out
        |-> dd_oe_out) else $error("write without data");
    AST_RD_OE: assert property (!dior_n_out |-> !dd_oe_out)
        else $error("read while driving");
endmodule : atb_assertions

// ==== testbench/atb_bridge_tb.sv ====
`timescale 1ns/1ps
bind atb_bridge atb_assertions u_ast (.clk_in(clk_in),
    .resetn_in(resetn_in), .wr_in(wr_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .master_in(master_in), .busy_out(busy_out),
    .dma_mode_in(dma_mode_in), .dma_start_in(dma_start_in),
    .ack_out(ack_out), .dma_done_out(dma_done_out), .cs1_out(cs1_out),
    .cs0_out(cs0_out), .da_out(da_out), .dior_n_out(dior_n_out),
    .diow_n_out(diow_n_out), .dd_oe_out(dd_oe_out));
module atb_bridge_tb;
    logic clk_in = 1'b0, resetn_in = 1'b0, ce_in = 1'b1, wr_in = 1'b0;
    logic rd_in = 1'b0, bus16_in = 1'b1, master_in = 1'b0;
    logic dma_start_in = 1'b0, dma_read_in = 1'b0;
    logic [1:0] dma_mode_in = 2'h0;
    logic [7:0] addr_in = 8'h00;
    logic [15:0] wdata_in = 16'h0000;
    logic ack_out, busy_out, dma_done_out, cs1_out, cs0_out;
    logic dior_n_out, diow_n_out, dd_oe_out;
    logic [2:0] da_out;
    logic [7:0] k;
    logic [15:0] dd_in, rdata_out, dd_out, q;
    int failures = 0, checked = 0, n, wcnt, seen;
    atb_bridge u_dut (.clk_in(clk_in), .resetn_in(resetn_in),
        .ce_in(ce_in), .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in),
        .wdata_in(wdata_in), .bus16_in(bus16_in), .master_in(master_in),
        .dma_mode_in(dma_mode_in), .dma_start_in(dma_start_in),
        .dma_read_in(dma_read_in), .dd_in(dd_in), .rdata_out(rdata_out),
        .ack_out(ack_out), .busy_out(busy_out),
        .dma_done_out(dma_done_out), .cs1_out(cs1_out), .cs0_out(cs0_out),
        .da_out(da_out), .dior_n_out(dior_n_out),
        .diow_n_out(diow_n_out), .dd_out(dd_out), .dd_oe_out(dd_oe_out));
    atb_drive_model u_drv (.clk_in(clk_in), .cs1_in(cs1_out),
        .cs0_in(cs0_out), .da_in(da_out), .dior_n_in(dior_n_out),
        .diow_n_in(diow_n_out), .dd_in(dd_out), .dd_out(dd_in));
    initial begin
        forever #50 clk_in = ~clk_in;
    end
    always @(negedge diow_n_out) wcnt++;
    // ==========
    // checking and host access tasks
    task automatic finish_test();
        $display("Mismatches %0d, checks %0d", failures, checked);
        if (failures == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("Error %0t: saw %h, wanted %h", $time, got, exp);
        end
    endtask : chk
    // reads pass the expected value in d, compared under mask m
    task automatic acc(input logic w, input logic [7:0] a,
        input logic [15:0] d, input logic [15:0] m = 16'hffff);
        @(negedge clk_in);
        wr_in = w;
        rd_in = ~w;
        addr_in = a;
        wdata_in = d;
        @(negedge clk_in);
        wr_in = 1'b0;
        rd_in = 1'b0;
        n = 0;
        while (ack_out !== 1'b1 && n < 20) begin
            @(negedge clk_in);
            n++;
        end
        q = rdata_out;
        while (busy_out !== 1'b0 && n < 30) begin
            @(negedge clk_in);
            n++;
        end
        if (n >= 20) begin
            failures++;
            $display("Error %0t: no answer from the bridge", $time);
            finish_test();
        end
        if (!w)
            chk(q & m, d);
    endtask : acc
    initial begin
        repeat (3) @(negedge clk_in);
        resetn_in = 1'b1;
        acc(1'b0, 8'h60, 16'h001f);
        acc(1'b0, 8'h70, 16'h0000);
        for (k = 8'h48; k < 8'h50; k++) begin
            acc(1'b1, k, {8'h00, k ^ 8'h5a});
            acc(1'b0, k, {8'h00, k ^ 8'h5a}, 16'h00ff);
        end
        acc(1'b1, 8'h40, 16'hbeef);
        acc(1'b0, 8'h40, 16'hbeef);
        acc(1'b1, 8'h44, 16'h00ec);
        acc(1'b0, 8'h44, 16'h00ff);
        // byte bus: the pair must make exactly one drive write
        bus16_in = 1'b0;
        wcnt = 0;
        acc(1'b1, 8'h40, 16'h0034);
        chk(16'(wcnt), 16'h0000);
        acc(1'b1, 8'h40, 16'h0012);
        chk(16'(wcnt), 16'h0001);
        acc(1'b0, 8'h40, 16'h0034, 16'h00ff);
        acc(1'b0, 8'h40, 16'h0012, 16'h00ff);
        acc(1'b1, 8'h49, 16'h0077);
        chk(16'(wcnt), 16'h0002);
        bus16_in = 1'b1;
        acc(1'b1, 8'h60, 16'h0002);
        acc(1'b0, 8'h60, 16'h0002);
        for (k = 8'h00; k < 8'h04; k++) begin
            master_in = (k != 8'h02);
            dma_mode_in = (k == 8'h01) ? 2'h2 : 2'h3;
            dma_read_in = (k == 8'h00);
            @(negedge clk_in);
            dma_start_in = 1'b1;
            @(negedge clk_in);
            dma_start_in = 1'b0;
            seen = 0;
            // a refused start shows nothing, so watch a fixed window
            repeat (12) begin
                @(negedge clk_in);
                seen += int'(dma_done_out === 1'b1);
            end
            chk(16'(seen), {15'h0000, k == 8'h00 || k == 8'h03});
        end
        finish_test();
    end
endmodule : atb_bridge_tb

// ==== testbench/atb_drive_model.sv ====
`timescale 1ns/1ps
// ==========
// behavioural drive; data lines have no pull, released bus is inverted
module atb_drive_model (
    input wire logic clk_in,
    input wire logic cs1_in,
    input wire logic cs0_in,
    input wire logic [2:0] da_in,
    input wire logic dior_n_in,
    input wire logic diow_n_in,
    input wire logic [15:0] dd_in,
    output logic [15:0] dd_out
);
    logic [15:0] regs_ff [0:15];
    logic [15:0] last_ff = 16'h0000;
    logic sel;
    logic [3:0] idx;
    assign sel = cs1_in ^ cs0_in;
    assign idx = {cs0_in, da_in};
    always @(posedge diow_n_in) begin
        if (sel)
            regs_ff[idx] <= dd_in;
    end
    always_ff @(posedge clk_in) begin
        if (!dior_n_in && sel)
            last_ff <= regs_ff[idx];
    end
    assign dd_out = (!dior_n_in && sel) ? regs_ff[idx] : ~last_ff;
endmodule : atb_drive_model
